/* common/swbd_pkg.sv */
// constants and types shared by the serial word boundary deserializer
//------------------------------------------------------------------------
//------------------------------------------------------------------------
package swbd_pkg;

  localparam int unsigned WORD_W      = 24;
  localparam int unsigned SER_W       = 26;
  localparam int unsigned CNT_W       = 16;
  localparam int unsigned CLK_MHZ     = 250;

  // word clock shape in bit times
  localparam logic [CNT_W-1:0] WCK_DELAY_BITS = 16'h0006;
  localparam logic [CNT_W-1:0] WCK_LOW_BITS   = 16'h000D;
  // half bit periods per reference period
  localparam logic [CNT_W-1:0] HALF_BITS_PER_REF = 16'h0034;

  // times in ns and derived counts
  localparam int unsigned PWRUP_PULSE_NS = 40;
  localparam int unsigned REF_IDLE_NS    = 8000;
  localparam int unsigned LOCK_COLD_NS   = 4000;
  localparam int unsigned LOCK_WARM_NS   = 1000;
  localparam logic [CNT_W-1:0] PWRUP_PULSE_CYC =
    CNT_W'((PWRUP_PULSE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] REF_IDLE_CYC =
    CNT_W'((REF_IDLE_NS * CLK_MHZ) / 1000);
  localparam logic [CNT_W-1:0] LOCK_COLD_CYC =
    CNT_W'((LOCK_COLD_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] LOCK_WARM_CYC =
    CNT_W'((LOCK_WARM_NS * CLK_MHZ + 999) / 1000);

  // control pin positions inside the parallel port
  localparam int unsigned CTL_LO = 20;
  localparam int unsigned CTL_HI = 22;

  // apb register map
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_WORD   = 8'h08;
  localparam logic [7:0] REG_COUNT  = 8'h0C;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0001;

  typedef enum logic [1:0] {WCK_IDLE, WCK_DELAY, WCK_LOW} swbd_wck_t;
  typedef enum logic [1:0] {PLL_OFF, PLL_LOCKING, PLL_ON} swbd_pll_t;

  typedef struct packed {
    logic              valid;
    logic [WORD_W-1:0] data;
  } swbd_word_t;

endpackage : swbd_pkg

/* logic/swbd_top.sv */
// serial word boundary deserializer with companion serializer and apb
module swbd_top
  import swbd_pkg::*;
(
  // clock and reset
  input  wire logic              I_CLK,
  input  wire logic              I_RST,
  // apb slave
  input  wire logic              I_PSEL,
  input  wire logic              I_PENABLE,
  input  wire logic              I_PWRITE,
  input  wire logic [7:0]        I_PADDR,
  input  wire logic [31:0]       I_PWDATA,
  output logic [31:0]            O_PRDATA,
  output logic                   O_PREADY,
  output logic                   O_PSLVERR,
  // mode and direction pins
  input  wire logic              I_MODE_SELECT_LOW,
  input  wire logic              I_MODE_SELECT_HIGH,
  input  wire logic              I_DIRECTION_SELECT_IN,
  output logic                   O_DIRECTION_INDICATE_OUT,
  // reference and strobe
  input  wire logic              I_PLL_REFERENCE_CLOCK,
  input  wire logic              I_STROBE,
  // serial link
  input  wire logic              I_SERIAL_CLOCK_IN_PAIR,
  input  wire logic              I_SERIAL_DATA_IN,
  output logic                   O_SERIAL_DATA_OUT_PAIR,
  output logic                   O_SERIAL_DATA_OE_N,
  output logic                   O_SERIAL_CLOCK_OUT_PAIR,
  output logic                   O_SERIAL_CLOCK_OE_N,
  output logic                   O_CLOCK_TERM_EN,
  output logic                   O_DATA_TERM_EN,
  // parallel port
  input  wire logic [WORD_W-1:0] I_PARALLEL_DATA_PORT,
  output logic [WORD_W-1:0]      O_PARALLEL_DATA_PORT,
  output logic [WORD_W-1:0]      O_PARALLEL_DATA_OE_N,
  output logic                   O_PARALLEL_WORD_CLOCK
);

  //----------------------------------------------------------------------
  // pin synchronisers
  //----------------------------------------------------------------------
  logic [6:0] s1_q, s2_q, s3_q;
  logic [6:0] pins;
  assign pins = {I_SERIAL_CLOCK_IN_PAIR, I_SERIAL_DATA_IN,
                 I_PLL_REFERENCE_CLOCK, I_STROBE, I_DIRECTION_SELECT_IN,
                 I_MODE_SELECT_LOW, I_MODE_SELECT_HIGH};

  always_ff @(posedge I_CLK) begin
    s1_q <= pins;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  logic sck, sck_p, sdi, sdi_p, ref_c, ref_p, stb, stb_p, dir_pin;
  logic msl, msh;
  assign {sck, sdi, ref_c, stb, dir_pin, msl, msh} = s2_q;
  assign {sck_p, sdi_p, ref_p, stb_p} = s3_q[6:3];

  logic pd, irst;
  assign pd   = ~msl & ~msh;
  assign irst = I_RST | pd;

  //----------------------------------------------------------------------
  // direction and power-up state
  //----------------------------------------------------------------------
  logic up_q, up_d, rx_q, rx_d;

  always_comb begin
    up_d = 1'b1;
    rx_d = up_q ? rx_q : ~dir_pin;
  end

  always_ff @(posedge I_CLK) begin
    if (irst) begin
      up_q <= 1'b0;
      rx_q <= 1'b0;
    end else begin
      up_q <= up_d;
      rx_q <= rx_d;
    end
  end

  // control pins are inputs or outputs depending on the mode
  logic [WORD_W-1:0] out_map;
  genvar gi;
  generate
    for (gi = 0; gi < WORD_W; gi++) begin : g_map
      if (gi < CTL_LO) begin : g_data
        assign out_map[gi] = 1'b1;
      end else if (gi < CTL_HI) begin : g_lo
        assign out_map[gi] = msl & ~msh;
      end else begin : g_hi
        assign out_map[gi] = msl;
      end
      assign O_PARALLEL_DATA_OE_N[gi] = ~(up_q & rx_q & out_map[gi]);
    end
  endgenerate

  //----------------------------------------------------------------------
  // apb registers
  //----------------------------------------------------------------------
  logic [31:0] ctrl_q, ctrl_d;
  logic        rx_en;
  logic        apb_acc, apb_wr;
  logic [31:0] rdata;
  logic        hit;
  logic        first_q;
  logic [CNT_W-1:0] wcount_q;
  swbd_word_t  word_q;
  swbd_pll_t   pll_q;

  assign apb_acc  = I_PSEL & I_PENABLE;
  assign apb_wr   = apb_acc & I_PWRITE;
  assign rx_en    = ctrl_q[0];
  assign O_PREADY = 1'b1;

  always_comb begin
    hit   = 1'b1;
    rdata = 32'h0000_0000;
    if (I_PADDR == REG_CTRL) begin
      rdata = ctrl_q;
    end else if (I_PADDR == REG_STATUS) begin
      rdata = {28'h0000000, first_q, pll_q == PLL_ON, rx_q, pd};
    end else if (I_PADDR == REG_WORD) begin
      rdata = {8'h00, word_q.data};
    end else if (I_PADDR == REG_COUNT) begin
      rdata = {16'h0000, wcount_q};
    end else begin
      hit = 1'b0;
    end
    ctrl_d = ctrl_q;
    if (apb_wr && I_PADDR == REG_CTRL) begin
      ctrl_d = {31'h00000000, I_PWDATA[0]};
    end
  end

  assign O_PRDATA  = (apb_acc & ~I_PWRITE) ? rdata : 32'h0000_0000;
  assign O_PSLVERR = apb_acc & ~hit;

  // the control register survives power-down so software keeps its settings
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      ctrl_q <= CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  //----------------------------------------------------------------------
  // deserializer: boundary search and word clock
  //----------------------------------------------------------------------
  logic             sck_rise, sck_fall;
  logic [CNT_W-1:0] per_cnt_q, per_cnt_d, bit_per_q, bit_per_d;
  logic [WORD_W-1:0] sr_q, sr_d;
  logic [1:0]       tog_q, tog_d;
  logic             bnd;
  logic [WORD_W-1:0] mapped;
  swbd_word_t       word_d;
  logic             first_d;
  logic [CNT_W-1:0] wcount_d;
  swbd_wck_t        wck_st_q, wck_st_d;
  logic [CNT_W-1:0] wck_cnt_q, wck_cnt_d;
  logic             wck_q, wck_d;

  // the received clock and data feed this section, gated by rx_q, rx_en and the mode pins
  assign sck_rise = sck & ~sck_p;
  assign sck_fall = ~sck & sck_p;
  // two data edges while the clock stays high mark the boundary
  assign bnd = sck_fall & (tog_q == 2'd2) & rx_q & rx_en;

  always_comb begin
    mapped = sr_q;
    if (msl & msh) begin
      mapped[CTL_HI +: 2] = sr_q[CTL_LO +: 2];
      mapped[CTL_LO +: 2] = 2'b00;
    end
  end

  always_comb begin
    per_cnt_d = (per_cnt_q == '1) ? per_cnt_q : per_cnt_q + 16'h0001;
    bit_per_d = bit_per_q;
    sr_d      = sr_q;
    tog_d     = tog_q;
    word_d    = word_q;
    first_d   = first_q;
    wcount_d  = wcount_q;
    wck_st_d  = wck_st_q;
    wck_cnt_d = wck_cnt_q;
    if (sck_rise) begin
      // a boundary rise comes after three bit times and does not set the bit period
      if (tog_q == 2'd0) begin
        bit_per_d = per_cnt_q;
      end
      per_cnt_d = 16'h0001;
      sr_d      = {sdi, sr_q[WORD_W-1:1]};
      tog_d     = 2'd0;
    end else if (sck && (sdi != sdi_p) && tog_q != 2'd2) begin
      tog_d = tog_q + 2'd1;
    end
    if (bnd) begin
      word_d   = '{valid: 1'b1, data: mapped};
      first_d  = 1'b1;
      wcount_d = wcount_q + 16'h0001;
    end
    case (wck_st_q)
      WCK_IDLE: begin
        if (!up_q && rx_d) begin
          wck_st_d  = WCK_LOW;
          wck_cnt_d = PWRUP_PULSE_CYC;
        end else if (bnd) begin
          wck_st_d  = WCK_DELAY;
          wck_cnt_d = CNT_W'(bit_per_q * WCK_DELAY_BITS);
        end
      end
      WCK_DELAY: begin
        if (wck_cnt_q <= 16'h0001) begin
          wck_st_d  = WCK_LOW;
          wck_cnt_d = CNT_W'(bit_per_q * WCK_LOW_BITS);
        end else begin
          wck_cnt_d = wck_cnt_q - 16'h0001;
        end
      end
      default: begin
        if (wck_cnt_q <= 16'h0001) begin
          wck_st_d = WCK_IDLE;
        end else begin
          wck_cnt_d = wck_cnt_q - 16'h0001;
        end
      end
    endcase
    wck_d = (wck_st_d != WCK_LOW);
  end

  always_ff @(posedge I_CLK) begin
    if (irst) begin
      per_cnt_q <= '0;
      bit_per_q <= '0;
      sr_q      <= '0;
      tog_q     <= 2'd0;
      word_q    <= '0;
      first_q   <= 1'b0;
      wcount_q  <= '0;
      wck_st_q  <= WCK_IDLE;
      wck_cnt_q <= '0;
      wck_q     <= 1'b1;
    end else begin
      per_cnt_q <= per_cnt_d;
      bit_per_q <= bit_per_d;
      sr_q      <= sr_d;
      tog_q     <= tog_d;
      word_q    <= word_d;
      first_q   <= first_d;
      wcount_q  <= wcount_d;
      wck_st_q  <= wck_st_d;
      wck_cnt_q <= wck_cnt_d;
      wck_q     <= wck_d;
    end
  end

  assign O_PARALLEL_DATA_PORT     = first_q ? word_q.data : '0;
  assign O_PARALLEL_WORD_CLOCK    = wck_q;
  assign O_DIRECTION_INDICATE_OUT = rx_q;
  assign O_CLOCK_TERM_EN          = 1'b1;
  assign O_DATA_TERM_EN           = up_q & rx_q;

  //----------------------------------------------------------------------
  // reference monitor and lock timer
  //----------------------------------------------------------------------
  logic             ref_rise;
  logic [CNT_W-1:0] ref_cnt_q, ref_cnt_d, ref_per_q, ref_per_d;
  logic [CNT_W-1:0] ref_pcnt_q, ref_pcnt_d;
  logic [CNT_W-1:0] lock_q, lock_d;
  logic             warm_q, warm_d;
  swbd_pll_t        pll_d;

  assign ref_rise = ref_c & ~ref_p;

  always_comb begin
    ref_cnt_d = (ref_cnt_q == '1) ? ref_cnt_q : ref_cnt_q + 16'h0001;
    ref_pcnt_d = (ref_pcnt_q == '1) ? ref_pcnt_q : ref_pcnt_q + 16'h0001;
    ref_per_d = ref_per_q;
    pll_d     = pll_q;
    lock_d    = lock_q;
    warm_d    = warm_q;
    if (ref_c != ref_p) begin
      ref_cnt_d = 16'h0001;
    end
    // rise to rise, so the duty cycle of the reference does not matter
    if (ref_rise) begin
      ref_per_d  = ref_pcnt_q;
      ref_pcnt_d = 16'h0001;
    end
    case (pll_q)
      PLL_OFF: begin
        if (ref_rise) begin
          pll_d  = PLL_LOCKING;
          lock_d = warm_q ? LOCK_WARM_CYC : LOCK_COLD_CYC;
        end
      end
      PLL_LOCKING: begin
        lock_d = lock_q - 16'h0001;
        if (lock_q <= 16'h0001) begin
          pll_d  = PLL_ON;
          warm_d = 1'b1;
        end
      end
      default: begin
        if (ref_cnt_q >= REF_IDLE_CYC) begin
          pll_d = PLL_OFF;
        end
      end
    endcase
    if (pll_q != PLL_OFF && ref_cnt_q >= REF_IDLE_CYC) begin
      pll_d = PLL_OFF;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (irst) begin
      ref_cnt_q <= '0;
      ref_per_q <= '0;
      ref_pcnt_q <= '0;
      pll_q     <= PLL_OFF;
      lock_q    <= '0;
      warm_q    <= 1'b0;
    end else begin
      ref_cnt_q <= ref_cnt_d;
      ref_per_q <= ref_per_d;
      ref_pcnt_q <= ref_pcnt_d;
      pll_q     <= pll_d;
      lock_q    <= lock_d;
      warm_q    <= warm_d;
    end
  end

  //----------------------------------------------------------------------
  // serializer and bit clock
  //----------------------------------------------------------------------
  logic             on;
  logic [CNT_W-1:0] half_per;
  logic [CNT_W-1:0] hcnt_q, hcnt_d;
  logic             hen;
  logic             phase_q, phase_d;
  logic [4:0]       bit_q, bit_d;
  logic             inw_q, inw_d;
  logic             pend_q, pend_d;
  logic [WORD_W-1:0] pword_q, pword_d;
  logic [SER_W-1:0] tx_q, tx_d;
  logic             skip;

  assign on = (pll_q == PLL_ON);
  // half a bit period is a 52th of the measured reference period
  assign half_per = (ref_per_q < HALF_BITS_PER_REF) ? 16'h0001 :
                    ref_per_q / HALF_BITS_PER_REF;
  assign hen  = on & (hcnt_q >= half_per - 16'h0001);
  assign skip = inw_q & (bit_q >= 5'(WORD_W));

  always_comb begin
    hcnt_d  = hen ? '0 : hcnt_q + 16'h0001;
    phase_d = phase_q;
    bit_d   = bit_q;
    inw_d   = inw_q;
    pend_d  = pend_q;
    pword_d = pword_q;
    tx_d    = tx_q;
    if (!on) begin
      hcnt_d = '0;
    end
    // inputs gated off while receiving; unused pins read as zero
    if (stb & ~stb_p & ~rx_q & on) begin
      pend_d  = 1'b1;
      pword_d = I_PARALLEL_DATA_PORT;
      // control pins that are outputs in this mode carry no data
      if (msl & ~msh) begin
        pword_d[WORD_W-1:CTL_LO] = '0;
      end else if (msl & msh) begin
        pword_d[CTL_HI +: 2] = 2'b00;
      end
    end
    if (hen) begin
      phase_d = ~phase_q;
      if (phase_q) begin
        if (inw_q && bit_q < 5'(SER_W - 1)) begin
          bit_d = bit_q + 5'd1;
        end else if (pend_q && !rx_q) begin
          inw_d  = 1'b1;
          bit_d  = 5'd0;
          pend_d = 1'b0;
          tx_d   = {pword_q[WORD_W-1], ~pword_q[WORD_W-1], pword_q};
        end else begin
          inw_d = 1'b0;
          bit_d = 5'd0;
        end
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (irst) begin
      hcnt_q  <= '0;
      phase_q <= 1'b1;
      bit_q   <= 5'd0;
      inw_q   <= 1'b0;
      pend_q  <= 1'b0;
      pword_q <= '0;
      tx_q    <= '0;
    end else begin
      hcnt_q  <= hcnt_d;
      phase_q <= phase_d;
      bit_q   <= bit_d;
      inw_q   <= inw_d;
      pend_q  <= pend_d;
      pword_q <= pword_d;
      tx_q    <= tx_d;
    end
  end

  // bit clock keeps running in receive direction while locked
  assign O_SERIAL_CLOCK_OUT_PAIR = phase_q | skip | ~on;
  assign O_SERIAL_CLOCK_OE_N     = ~on;
  assign O_SERIAL_DATA_OUT_PAIR  = inw_q & tx_q[bit_q] & ~rx_q;
  assign O_SERIAL_DATA_OE_N      = ~(on & up_q & ~rx_q);

  //----------------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------------
  property p_zero_before_word;
    @(posedge I_CLK) disable iff (I_RST)
      !first_q |-> O_PARALLEL_DATA_PORT == '0;
  endproperty
  a_zero_before_word: assert property (p_zero_before_word)
    else $error("parallel data not zero before first word");

  property p_bnd_delay;
    @(posedge I_CLK) disable iff (I_RST)
      (bnd && wck_st_q == WCK_IDLE && up_q && !pd)
        |=> wck_st_q == WCK_DELAY && O_PARALLEL_WORD_CLOCK
            && wck_cnt_q == CNT_W'(bit_per_q * WCK_DELAY_BITS);
  endproperty
  a_bnd_delay: assert property (p_bnd_delay)
    else $error("word clock delay not started on boundary");

  property p_low_end;
    @(posedge I_CLK) disable iff (I_RST)
      (wck_st_q == WCK_LOW && wck_cnt_q == 16'h0001 && !pd)
        |=> O_PARALLEL_WORD_CLOCK;
  endproperty
  a_low_end: assert property (p_low_end)
    else $error("word clock low time wrong");

  property p_high_no_bnd;
    @(posedge I_CLK) disable iff (I_RST)
      (up_q && !rx_q) |=> O_PARALLEL_WORD_CLOCK;
  endproperty
  a_high_no_bnd: assert property (p_high_no_bnd)
    else $error("word clock pulsed while transmitting");

  property p_pins_released;
    @(posedge I_CLK) disable iff (I_RST)
      !rx_q |-> &O_PARALLEL_DATA_OE_N;
  endproperty
  a_pins_released: assert property (p_pins_released)
    else $error("parallel pins driven while transmitting");

  property p_pd_hiz;
    @(posedge I_CLK) disable iff (I_RST)
      pd |=> O_SERIAL_CLOCK_OE_N && O_SERIAL_DATA_OE_N;
  endproperty
  a_pd_hiz: assert property (p_pd_hiz)
    else $error("differential drivers active in power-down");

  property p_bnd_bits;
    @(posedge I_CLK) disable iff (I_RST)
      inw_q |-> tx_q[WORD_W] != tx_q[WORD_W-1]
                && tx_q[WORD_W+1] == tx_q[WORD_W-1];
  endproperty
  a_bnd_bits: assert property (p_bnd_bits)
    else $error("boundary bits malformed");

  property p_skip_high;
    @(posedge I_CLK) disable iff (I_RST)
      (inw_q && bit_q >= 5'(WORD_W)) |-> O_SERIAL_CLOCK_OUT_PAIR;
  endproperty
  a_skip_high: assert property (p_skip_high)
    else $error("serial clock low during boundary");

  property p_hold_data;
    @(posedge I_CLK) disable iff (I_RST)
      (!bnd && !pd && !$past(pd)) |=> $stable(O_PARALLEL_DATA_PORT);
  endproperty
  a_hold_data: assert property (p_hold_data)
    else $error("parallel data changed without boundary");

  property p_ref_idle;
    @(posedge I_CLK) disable iff (I_RST)
      (on && ref_cnt_q >= REF_IDLE_CYC && !pd) |=> pll_q == PLL_OFF;
  endproperty
  a_ref_idle: assert property (p_ref_idle)
    else $error("pll not shut down on idle reference");

  c_word: cover property (@(posedge I_CLK) disable iff (I_RST) bnd);
  c_low: cover property (@(posedge I_CLK) disable iff (I_RST)
    $fell(O_PARALLEL_WORD_CLOCK) && first_q);
  c_tx: cover property (@(posedge I_CLK) disable iff (I_RST)
    inw_q && bit_q == 5'(SER_W - 1));

endmodule : swbd_top

/* bench/swbd_partner.sv */
// serializer model that drives the serial clock and data into the block
module swbd_partner (
  // clock
  input  wire logic clk,
  // serial link towards the block
  output logic      sck,
  output logic      sdat
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sck  = 1'b0;
    sdat = 1'b0;
  end
  // half a bit is ten system cycles, so the link runs at 80 ns a bit
  task automatic half();
    repeat (10) @(posedge clk);
  endtask : half
  // hi keeps the clock high: that is the skipped low pulse
  task automatic bit_out(input logic b, input logic hi);
    if (!hi) sck <= 1'b0;
    sdat <= b;
    half();
    sck <= 1'b1;
    half();
  endtask : bit_out
  task automatic send_word(input logic [23:0] w);
    for (int i = 0; i < 24; i++) bit_out(w[i], 1'b0);
    bit_out(~w[23], 1'b1);
    bit_out(w[23], 1'b1);
    // clock stands low between frames
    sck <= 1'b0;
    @(posedge clk);
  endtask : send_word
  task automatic send_fill(input int n);
    for (int i = 0; i < n; i++) bit_out(1'b0, 1'b0);
    sck <= 1'b0;
    @(posedge clk);
  endtask : send_fill
endmodule : swbd_partner

/* bench/test_swbd_top.sv */
// self-checking bench for the word boundary deserializer
module test_swbd_top;
  import swbd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic              I_CLK = 1'b0;
  logic              I_RST = 1'b1;
  logic              I_PSEL = 1'b0, I_PENABLE = 1'b0, I_PWRITE = 1'b0;
  logic [7:0]        I_PADDR = 8'h00;
  logic [31:0]       I_PWDATA = 32'h0, O_PRDATA;
  logic              O_PREADY, O_PSLVERR, O_DIRECTION_INDICATE_OUT;
  logic              I_MODE_SELECT_LOW = 1'b1, I_MODE_SELECT_HIGH = 1'b0;
  logic              I_DIRECTION_SELECT_IN = 1'b0, ref_on = 1'b0;
  logic              I_PLL_REFERENCE_CLOCK = 1'b0, I_STROBE = 1'b0;
  logic              O_SERIAL_DATA_OUT_PAIR, O_SERIAL_CLOCK_OUT_PAIR;
  logic              O_SERIAL_CLOCK_OE_N, sck_o_p = 1'b1;
  logic [WORD_W-1:0] I_PARALLEL_DATA_PORT = 24'h000000;
  logic [WORD_W-1:0] tx_cap = 24'h000000, tx_word = 24'h000000;
  logic              sck, sdat, O_SERIAL_DATA_OE_N, O_CLOCK_TERM_EN;
  logic              O_DATA_TERM_EN, O_PARALLEL_WORD_CLOCK;
  logic [WORD_W-1:0] O_PARALLEL_DATA_PORT, O_PARALLEL_DATA_OE_N;
  logic [31:0]       rd;
  logic              er;
  int                err_total = 0, comparisons = 0, lows = 0;
  int                rises = 0, frames = 0, hi_n = 0;
  initial forever #2 I_CLK = ~I_CLK;
  // reference for the transmit role: 208 system cycles a period
  initial forever begin
    repeat (104) @(posedge I_CLK);
    if (ref_on) I_PLL_REFERENCE_CLOCK <= ~I_PLL_REFERENCE_CLOCK;
  end
  always @(posedge I_CLK) begin
    if (O_PARALLEL_WORD_CLOCK === 1'b0) lows <= lows + 1;
    // outgoing link watcher: one bit is taken at every clock rise
    sck_o_p <= O_SERIAL_CLOCK_OUT_PAIR;
    if (O_SERIAL_CLOCK_OUT_PAIR === 1'b1 && sck_o_p === 1'b0) begin
      rises <= rises + 1;
      tx_cap <= {O_SERIAL_DATA_OUT_PAIR, tx_cap[WORD_W-1:1]};
    end
    hi_n <= (O_SERIAL_CLOCK_OUT_PAIR === 1'b1) ? hi_n + 1 : 0;
    // a high run longer than a bit while driving is a boundary
    if (hi_n == 8 && O_SERIAL_CLOCK_OE_N === 1'b0) begin
      frames <= frames + 1;
      tx_word <= tx_cap;
    end
  end
  swbd_partner swbd_partner_inst (.clk(I_CLK), .sck(sck), .sdat(sdat));
  swbd_top swbd_top_inst (
    .I_CLK(I_CLK), .I_RST(I_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
    .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
    .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .I_MODE_SELECT_LOW(I_MODE_SELECT_LOW),
    .I_MODE_SELECT_HIGH(I_MODE_SELECT_HIGH),
    .I_DIRECTION_SELECT_IN(I_DIRECTION_SELECT_IN),
    .O_DIRECTION_INDICATE_OUT(O_DIRECTION_INDICATE_OUT),
    .I_PLL_REFERENCE_CLOCK(I_PLL_REFERENCE_CLOCK), .I_STROBE(I_STROBE),
    .I_SERIAL_CLOCK_IN_PAIR(sck), .I_SERIAL_DATA_IN(sdat),
    .O_SERIAL_DATA_OUT_PAIR(O_SERIAL_DATA_OUT_PAIR),
    .O_SERIAL_DATA_OE_N(O_SERIAL_DATA_OE_N),
    .O_SERIAL_CLOCK_OUT_PAIR(O_SERIAL_CLOCK_OUT_PAIR),
    .O_SERIAL_CLOCK_OE_N(O_SERIAL_CLOCK_OE_N),
    .O_CLOCK_TERM_EN(O_CLOCK_TERM_EN), .O_DATA_TERM_EN(O_DATA_TERM_EN),
    .I_PARALLEL_DATA_PORT(I_PARALLEL_DATA_PORT),
    .O_PARALLEL_DATA_PORT(O_PARALLEL_DATA_PORT),
    .O_PARALLEL_DATA_OE_N(O_PARALLEL_DATA_OE_N),
    .O_PARALLEL_WORD_CLOCK(O_PARALLEL_WORD_CLOCK));
  //----------------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------------
  task automatic cmp(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    comparisons++;
    if (got !== ex) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, ex, got);
    end
  endtask : cmp
  task automatic cmp_rng(input string nm, input int v, input int lo,
                         input int hi);
    comparisons++;
    if (v < lo || v > hi) begin
      err_total++;
      $display("[ERR] %s exp %0d..%0d got %0d", nm, lo, hi, v);
    end
  endtask : cmp_rng
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge I_CLK);
    I_PSEL <= 1'b1;
    I_PWRITE <= w;
    I_PADDR <= a;
    I_PWDATA <= d;
    @(posedge I_CLK);
    I_PENABLE <= 1'b1;
    do begin
      @(posedge I_CLK);
    end while (O_PREADY !== 1'b1);
    rd = O_PRDATA;
    er = O_PSLVERR;
    I_PSEL <= 1'b0;
    I_PENABLE <= 1'b0;
  endtask : apb
  // waits for the word clock to reach level v, returns the cycles waited
  task automatic wait_wck(input logic v, input int lim, output int n);
    n = 0;
    while (O_PARALLEL_WORD_CLOCK !== v && n < lim) begin
      @(posedge I_CLK);
      n++;
    end
  endtask : wait_wck
  task automatic rx(input logic [23:0] w, input logic [23:0] e,
                    input bit pulse);
    int d, l, l0;
    l0 = lows;
    swbd_partner_inst.send_word(w);
    if (pulse) begin
      wait_wck(1'b0, 400, d);
      cmp_rng("wck delay", d, 118, 130);
      wait_wck(1'b1, 400, l);
      cmp_rng("wck low", l, 255, 265);
    end else begin
      repeat (400) @(posedge I_CLK);
      cmp("no pulse", l0, lows);
    end
    cmp("word", e, O_PARALLEL_DATA_PORT);
  endtask : rx
  task automatic power_up(input logic lo, input logic hi);
    int n;
    I_MODE_SELECT_LOW <= lo;
    I_MODE_SELECT_HIGH <= hi;
    wait_wck(1'b0, 40, n);
    wait_wck(1'b1, 40, n);
    cmp_rng("pwrup pulse", n, 8, 12);
    cmp("data idle", 0, O_PARALLEL_DATA_PORT);
  endtask : power_up
  task automatic give_verdict();
    if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  //----------------------------------------------------------------------
  // tests
  //----------------------------------------------------------------------
  initial begin
    repeat (40000) @(posedge I_CLK);
    err_total++;
    give_verdict();
  end
  initial begin
    int l0, n;
    repeat (20) @(posedge I_CLK);
    I_RST <= 1'b0;
    power_up(1'b1, 1'b0);
    cmp("dir out", 1, O_DIRECTION_INDICATE_OUT);
    cmp("oe mode1", 24'h000000, O_PARALLEL_DATA_OE_N);
    cmp("term", 2'b11, {O_CLOCK_TERM_EN, O_DATA_TERM_EN});
    cmp("ser oe", 1, O_SERIAL_DATA_OE_N);
    l0 = lows;
    swbd_partner_inst.send_fill(12);
    cmp("fill", l0, lows);
    cmp("fill data", 0, O_PARALLEL_DATA_PORT);
    rx(24'hA5C3F1, 24'hA5C3F1, 1'b1);
    rx(24'h800001, 24'h800001, 1'b1);
    apb(1'b0, REG_COUNT, 32'h0);
    cmp("count", 2, rd[15:0]);
    apb(1'b0, REG_WORD, 32'h0);
    cmp("last", 32'h00800001, rd);
    apb(1'b0, 8'h10, 32'h0);
    cmp("unmapped err", 1, er);
    cmp("unmapped data", 0, rd);
    apb(1'b1, REG_CTRL, 32'h0);
    rx(24'h123456, 24'h800001, 1'b0);
    apb(1'b1, REG_CTRL, CTRL_RST);
    I_MODE_SELECT_LOW <= 1'b0;
    repeat (10) @(posedge I_CLK);
    cmp("pd data", 0, O_PARALLEL_DATA_PORT);
    cmp("pd term", 0, O_DATA_TERM_EN);
    power_up(1'b1, 1'b1);
    cmp("oe mode3", 24'h300000, O_PARALLEL_DATA_OE_N);
    rx(24'h355AA5, 24'hC55AA5, 1'b1);
    // transmit role, taken from the direction pin at power-up
    I_MODE_SELECT_LOW <= 1'b0;
    I_MODE_SELECT_HIGH <= 1'b0;
    I_DIRECTION_SELECT_IN <= 1'b1;
    repeat (10) @(posedge I_CLK);
    I_MODE_SELECT_LOW <= 1'b1;
    l0 = lows;
    repeat (20) @(posedge I_CLK);
    cmp("dir tx", 0, O_DIRECTION_INDICATE_OUT);
    cmp("oe tx", 24'hFFFFFF, O_PARALLEL_DATA_OE_N);
    cmp("unlocked", 2'b11, {O_SERIAL_CLOCK_OE_N, O_SERIAL_DATA_OE_N});
    ref_on = 1'b1;
    repeat (1400) @(posedge I_CLK);
    cmp("locked", 2'b00, {O_SERIAL_CLOCK_OE_N, O_SERIAL_DATA_OE_N});
    apb(1'b0, REG_STATUS, 32'h0);
    cmp("status", 32'h00000004, rd);
    n = rises;
    repeat (832) @(posedge I_CLK);
    cmp_rng("bit rate", rises - n, 103, 105);
    n = frames;
    I_PARALLEL_DATA_PORT <= 24'hFABCDE;
    repeat (4) @(posedge I_CLK);
    I_STROBE <= 1'b1;
    repeat (600) @(posedge I_CLK);
    I_STROBE <= 1'b0;
    cmp("frames", 1, frames - n);
    cmp("tx word", 24'h0ABCDE, tx_word);
    cmp("tx wck", l0, lows);
    ref_on = 1'b0;
    repeat (2200) @(posedge I_CLK);
    cmp("ref stop", 1, O_SERIAL_CLOCK_OE_N);
    ref_on = 1'b1;
    repeat (550) @(posedge I_CLK);
    cmp("relock", 0, O_SERIAL_CLOCK_OE_N);
    give_verdict();
  end
endmodule : test_swbd_top
